/* File: nvp_pkg.sv */
package nvp_pkg;

  // register indices; byte address on APB is four times the index
  localparam logic [23:0] IDX_CODE_PROTECT = 24'h30_0008;
  localparam logic [23:0] IDX_READ_GUARD   = 24'h30_000a;
  localparam logic [23:0] IDX_REVISION     = 24'h3f_fffc;
  localparam logic [23:0] IDX_PART_ID      = 24'h3f_fffe;

  localparam int IDX_W  = 24;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int WORD_W = 16;

  // code protect word fields
  localparam int PROT_PROG_BIT = 0;
  localparam int PROT_DATA_BIT = 1;
  localparam logic [1:0] PROT_RESET = 2'h3;

  // table read guard word fields
  localparam int GUARD_BOOT_BIT = 9;
  localparam int NUM_BLOCKS     = 4;
  localparam logic [15:0] GUARD_RESET = 16'h020f;
  localparam logic [15:0] GUARD_MASK  = 16'h020f;

  // revision word fields
  localparam int REV_FAM_LSB = 12;
  localparam int REV_MAJ_LSB = 6;
  localparam int REV_MIN_LSB = 0;
  localparam int FAM_W       = 4;
  localparam int REV_W       = 6;

  // memory regions seen by table reads
  typedef enum logic [2:0] {
    NVP_REG_BOOT,
    NVP_REG_BLK0,
    NVP_REG_BLK1,
    NVP_REG_BLK2,
    NVP_REG_BLK3,
    NVP_REG_OTHER
  } nvp_region_t;

  // memory space seen by the programming interface
  typedef enum logic {
    NVP_SPACE_PROGRAM,
    NVP_SPACE_DATA
  } nvp_space_t;

  typedef struct packed {
    logic        valid;
    nvp_region_t source;
    nvp_region_t target;
  } nvp_tblrd_req_t;

  typedef struct packed {
    logic       valid;
    nvp_space_t space;
  } nvp_ext_req_t;

  typedef struct packed {
    logic grant;
    logic deny;
  } nvp_resp_t;

endpackage

/* File: nvp_protect_regs.sv */
// Overview of operation
// - data memory code protection is active while the data protect bit is 0 and off while it is 1.
// - program memory code protection is active while the program protect bit is 0 and off while it is 1.
// - a boot guard bit of 0 blocks table reads of the boot block issued from other blocks; 1 allows them.
// - each of the four numbered blocks blocks table reads from other blocks while its guard bit is 0.
// - the part identity word reads a fixed 16-bit value that fills the whole word.
// - the top four bits of the revision word always read the fixed family constant and cannot be written.
// - the middle six bits of the revision word give the major revision number.
// - the lowest six bits of the revision word give the read-only minor revision number.
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module nvp_protect_regs #(
  parameter logic [15:0] PART_ID   = 16'h1234, // arbitrary value
  parameter logic [3:0]  FAMILY    = 4'h5,     // arbitrary value
  parameter logic [5:0]  MAJOR_REV = 6'h01,    // arbitrary value
  parameter logic [5:0]  MINOR_REV = 6'h02     // arbitrary value
) (
  input  wire logic                         core_clk,        // 200 MHz clock
  input  wire logic                         rst,             // sync reset, high
  input  wire logic [nvp_pkg::ADDR_W-1:0]   paddr,           // apb address
  input  wire logic                         psel,            // apb select
  input  wire logic                         penable,         // apb enable
  input  wire logic                         pwrite,          // apb direction
  input  wire logic [nvp_pkg::DATA_W-1:0]   pwdata,          // apb write data
  input  wire logic [3:0]                   pstrb,           // apb byte strobes
  output logic      [nvp_pkg::DATA_W-1:0]   prdata,          // apb read data
  output logic                              pready,          // apb ready
  output logic                              pslverr,         // apb error
  input  wire logic [1:0]                   nvm_code_cfg,    // stored protect bits
  input  var  nvp_pkg::nvp_tblrd_req_t      tblrd_req,       // table read request
  output nvp_pkg::nvp_resp_t                tblrd_resp,      // table read verdict
  input  var  nvp_pkg::nvp_ext_req_t        ext_req,         // external read request
  output nvp_pkg::nvp_resp_t                ext_resp,        // external read verdict
  output logic                              data_protect_on, // data memory guarded
  output logic                              prog_protect_on, // program memory guarded
  output logic                              boot_guard_on,   // boot block read guard
  output logic      [nvp_pkg::NUM_BLOCKS-1:0] block_guard_on // block read guards
);

  // guard bit that covers a region; regions outside the table are open
  function automatic logic guard_bit(input logic [15:0] word, input nvp_pkg::nvp_region_t reg_id);
    logic g;
    g = 1'b1;
    case (reg_id)
      nvp_pkg::NVP_REG_BOOT: g = word[nvp_pkg::GUARD_BOOT_BIT];
      nvp_pkg::NVP_REG_BLK0: g = word[0];
      nvp_pkg::NVP_REG_BLK1: g = word[1];
      nvp_pkg::NVP_REG_BLK2: g = word[2];
      nvp_pkg::NVP_REG_BLK3: g = word[3];
      default:               g = 1'b1;
    endcase
    return g;
  endfunction

  // byte address of a register index; upper address bits must be zero
  function automatic logic hit(input logic [nvp_pkg::ADDR_W-1:0] a, input logic [23:0] idx);
    logic [nvp_pkg::ADDR_W-1:0] byte_addr;
    byte_addr = {6'h00, idx, 2'h0};
    return a == byte_addr;
  endfunction

  logic [1:0]  code_protect;
  logic [1:0]  next_code_protect;
  logic [15:0] read_guard;
  logic [15:0] next_read_guard;
  logic [15:0] revision_word;
  logic [15:0] part_word;
  logic [15:0] guard_wdata;

  logic [nvp_pkg::DATA_W-1:0] next_prdata;
  logic                       next_pslverr;
  nvp_pkg::nvp_resp_t         next_tblrd_resp;
  nvp_pkg::nvp_resp_t         next_ext_resp;

  logic setup;
  logic access;
  logic sel_prot;
  logic sel_guard;
  logic sel_rev;
  logic sel_part;
  logic mapped;
  logic wr_guard;

  // field view of the stored and fixed words
  logic                           data_mem_protect_n;
  logic                           program_mem_protect_n;
  logic                           boot_read_guard_n;
  logic [nvp_pkg::NUM_BLOCKS-1:0] block_read_guard_n;
  logic [nvp_pkg::FAM_W-1:0]      family_field;
  logic [nvp_pkg::REV_W-1:0]      major_revision_field;
  logic [nvp_pkg::REV_W-1:0]      minor_revision_field;
  logic [nvp_pkg::WORD_W-1:0]     part_identity_field;

  // identity words are pure constants: no storage, nothing to corrupt
  assign family_field         = FAMILY;
  assign major_revision_field = MAJOR_REV;
  assign minor_revision_field = MINOR_REV;
  assign part_identity_field  = PART_ID;
  assign revision_word        = {family_field, major_revision_field, minor_revision_field};
  assign part_word            = part_identity_field;

  assign setup     = psel && !penable;
  assign access    = psel && penable;
  // only the four aligned word addresses decode; anything else answers with an error
  assign sel_prot  = hit(paddr, nvp_pkg::IDX_CODE_PROTECT);
  assign sel_guard = hit(paddr, nvp_pkg::IDX_READ_GUARD);
  assign sel_rev   = hit(paddr, nvp_pkg::IDX_REVISION);
  assign sel_part  = hit(paddr, nvp_pkg::IDX_PART_ID);
  assign mapped    = sel_prot || sel_guard || sel_rev || sel_part;
  assign wr_guard  = access && pwrite && sel_guard;

  // zero wait state: every access completes in its first access cycle
  assign pready = 1'b1;

  // code protect word follows the stored nvm bits; software cannot write it
  always_comb
  begin
    next_code_protect = nvm_code_cfg;
  end

  // a change of the stored bits reaches the guards one clock later
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      code_protect <= nvp_pkg::PROT_RESET;
    end
    else
    begin
      code_protect <= next_code_protect;
    end
  end

  assign data_mem_protect_n    = code_protect[nvp_pkg::PROT_DATA_BIT];
  assign program_mem_protect_n = code_protect[nvp_pkg::PROT_PROG_BIT];
  assign data_protect_on       = !data_mem_protect_n;
  assign prog_protect_on       = !program_mem_protect_n;

  // byte lanes merged so a partial write keeps the other lane;
  // the upper two strobes have no lane to steer and are ignored
  genvar li;
  generate
    for (li = 0; li < nvp_pkg::WORD_W / 8; li++)
    begin : g_lane
      assign guard_wdata[li*8 +: 8] = pstrb[li] ? pwdata[li*8 +: 8] : read_guard[li*8 +: 8];
    end
  endgenerate

  // reserved bits are masked off so they always read 0
  always_comb
  begin
    next_read_guard = read_guard;
    if (wr_guard)
    begin
      next_read_guard = guard_wdata & nvp_pkg::GUARD_MASK;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      read_guard <= nvp_pkg::GUARD_RESET;
    end
    else
    begin
      read_guard <= next_read_guard;
    end
  end

  assign boot_read_guard_n  = read_guard[nvp_pkg::GUARD_BOOT_BIT];
  assign block_read_guard_n = read_guard[nvp_pkg::NUM_BLOCKS-1:0];
  assign boot_guard_on      = !boot_read_guard_n;

  genvar gi;
  generate
    for (gi = 0; gi < nvp_pkg::NUM_BLOCKS; gi++)
    begin : g_blk
      assign block_guard_on[gi] = !block_read_guard_n[gi];
    end
  endgenerate

  // apb read path; the upper half of the read data is always 0
  // data captured in setup so it stands stable through the access cycle
  always_comb
  begin
    next_prdata  = prdata;
    next_pslverr = 1'b0;
    if (setup)
    begin
      next_prdata = '0;
      if (!pwrite)
      begin
        if (sel_prot)
        begin
          next_prdata[1:0] = code_protect;
        end
        else if (sel_guard)
        begin
          next_prdata[15:0] = read_guard;
        end
        else if (sel_rev)
        begin
          next_prdata[15:0] = revision_word;
        end
        else if (sel_part)
        begin
          next_prdata[15:0] = part_word;
        end
      end
      next_pslverr = !mapped;
    end
    else if (access)
    begin
      next_pslverr = pslverr;
    end
  end

  // writes to read-only words fall through with no effect and no error
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end
    else
    begin
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // table read gate
  // reads within the same block are never guarded
  always_comb
  begin
    next_tblrd_resp = '0;
    if (tblrd_req.valid)
    begin
      if (tblrd_req.source == tblrd_req.target || guard_bit(read_guard, tblrd_req.target))
      begin
        next_tblrd_resp.grant = 1'b1;
      end
      else
      begin
        next_tblrd_resp.deny = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      tblrd_resp <= '0;
    end
    else
    begin
      tblrd_resp <= next_tblrd_resp;
    end
  end

  // external read gate; the verdict is registered and stays up for as many cycles as the request is held
  always_comb
  begin
    next_ext_resp = '0;
    if (ext_req.valid)
    begin
      case (ext_req.space)
        nvp_pkg::NVP_SPACE_DATA:
        begin
          next_ext_resp.deny  = data_protect_on;
          next_ext_resp.grant = !data_protect_on;
        end
        nvp_pkg::NVP_SPACE_PROGRAM:
        begin
          next_ext_resp.deny  = prog_protect_on;
          next_ext_resp.grant = !prog_protect_on;
        end
        default:
        begin
          next_ext_resp.deny = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ext_resp <= '0;
    end
    else
    begin
      ext_resp <= next_ext_resp;
    end
  end

endmodule

`default_nettype wire

/* File: nvp_protect_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module nvp_protect_monitor #(
  parameter logic [15:0] PART_ID   = 16'h0000,
  parameter logic [3:0]  FAMILY    = 4'h0,
  parameter logic [5:0]  MAJOR_REV = 6'h00,
  parameter logic [5:0]  MINOR_REV = 6'h00
) (
  input wire logic                    core_clk,        // clock
  input wire logic                    rst,             // reset
  input wire logic [31:0]             paddr,           // apb address
  input wire logic                    psel,            // apb select
  input wire logic                    penable,         // apb enable
  input wire logic                    pwrite,          // apb direction
  input wire logic [31:0]             pwdata,          // apb write data
  input wire logic [3:0]              pstrb,           // apb strobes
  input wire logic [31:0]             prdata,          // apb read data
  input wire logic [1:0]              nvm_code_cfg,    // stored bits
  input var  nvp_pkg::nvp_tblrd_req_t tblrd_req,       // table read
  input var  nvp_pkg::nvp_resp_t      tblrd_resp,      // its verdict
  input var  nvp_pkg::nvp_ext_req_t   ext_req,         // external read
  input var  nvp_pkg::nvp_resp_t      ext_resp,        // its verdict
  input wire logic                    data_protect_on, // data guarded
  input wire logic                    prog_protect_on, // program guarded
  input wire logic                    boot_guard_on,   // boot guard
  input wire logic [3:0]              block_guard_on   // block guards
);
  localparam logic [31:0] A_GUARD = {6'h00, nvp_pkg::IDX_READ_GUARD, 2'h0};
  localparam logic [31:0] A_REV   = {6'h00, nvp_pkg::IDX_REVISION, 2'h0};
  localparam logic [31:0] A_PART  = {6'h00, nvp_pkg::IDX_PART_ID, 2'h0};
  logic exp_deny;
  logic setup_rd;
  // same-block reads are never blocked
  always_comb
  begin
    exp_deny = 1'b0;
    if (tblrd_req.source != tblrd_req.target)
    begin
      if (tblrd_req.target == nvp_pkg::NVP_REG_BOOT)
        exp_deny = boot_guard_on;
      else if (tblrd_req.target <= nvp_pkg::NVP_REG_BLK3)
        exp_deny = block_guard_on[2'(tblrd_req.target - 3'h1)];
    end
  end
  assign setup_rd = psel && !penable && !pwrite;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  data_prot_a: assert property (!$past(rst) |-> data_protect_on == !$past(nvm_code_cfg[1]))
    else $error("data protect not following stored bit");
  prog_prot_a: assert property (!$past(rst) |-> prog_protect_on == !$past(nvm_code_cfg[0]))
    else $error("program protect not following stored bit");
  ext_verdict_a: assert property (ext_req.valid |=> ext_resp.deny ==
    $past(ext_req.space ? data_protect_on : prog_protect_on) && ext_resp.grant == !ext_resp.deny)
    else $error("external read verdict wrong");
  tbl_verdict_a: assert property (tblrd_req.valid |=> tblrd_resp.deny == $past(exp_deny)
    && tblrd_resp.grant == !tblrd_resp.deny) else $error("table read verdict wrong");
  tbl_pulse_a: assert property ((tblrd_resp.grant || tblrd_resp.deny) |-> $past(tblrd_req.valid))
    else $error("table read verdict without request");
  boot_wr_a: assert property (psel && penable && pwrite && paddr == A_GUARD && pstrb[1] |=>
    boot_guard_on == !$past(pwdata[9])) else $error("boot guard write lost");
  block_wr_a: assert property (psel && penable && pwrite && paddr == A_GUARD && pstrb[0] |=>
    block_guard_on == ~$past(pwdata[3:0])) else $error("block guard write lost");
  part_id_a: assert property (setup_rd && paddr == A_PART |=> prdata == {16'h0000, PART_ID})
    else $error("part identity read wrong");
  rev_word_a: assert property (setup_rd && paddr == A_REV |=>
    prdata == {16'h0000, FAMILY, MAJOR_REV, MINOR_REV}) else $error("revision read wrong");
endmodule
`default_nettype wire

/* File: nvp_protect_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module nvp_protect_regs_tb;
  localparam logic [15:0] PID     = 16'hc3a5; // arbitrary value
  localparam logic [15:0] REV     = 16'h9a95; // arbitrary value
  localparam logic [31:0] A_PROT  = {6'h00, nvp_pkg::IDX_CODE_PROTECT, 2'h0};
  localparam logic [31:0] A_GUARD = {6'h00, nvp_pkg::IDX_READ_GUARD, 2'h0};
  localparam logic [31:0] A_REV   = {6'h00, nvp_pkg::IDX_REVISION, 2'h0};
  localparam logic [31:0] A_PART  = {6'h00, nvp_pkg::IDX_PART_ID, 2'h0};
  logic                    core_clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic                    data_protect_on, prog_protect_on, boot_guard_on;
  logic [31:0]             paddr, pwdata, prdata, rd;
  logic [3:0]              pstrb, block_guard_on;
  logic [1:0]              nvm_code_cfg;
  nvp_pkg::nvp_tblrd_req_t tblrd_req;
  nvp_pkg::nvp_ext_req_t   ext_req;
  nvp_pkg::nvp_resp_t      tblrd_resp, ext_resp;
  int                      errors, checks_done;
  nvp_protect_regs #(.PART_ID(PID), .FAMILY(REV[15:12]), .MAJOR_REV(REV[11:6]), .MINOR_REV(REV[5:0]))
  nvp_protect_regs_i (.core_clk(core_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nvm_code_cfg(nvm_code_cfg), .tblrd_req(tblrd_req), .tblrd_resp(tblrd_resp), .ext_req(ext_req),
    .ext_resp(ext_resp), .data_protect_on(data_protect_on), .prog_protect_on(prog_protect_on),
    .boot_guard_on(boot_guard_on), .block_guard_on(block_guard_on));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // idle edge first so a release and the next setup never share a time step
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, 4'hf);
    chk(rd, exp);
    chk({30'h0000_0000, err, pready}, 32'h0000_0001);
  endtask
  task automatic tbl(input nvp_pkg::nvp_region_t s, input nvp_pkg::nvp_region_t t, input logic dn);
    @(posedge core_clk);
    tblrd_req <= '{1'b1, s, t};
    @(posedge core_clk);
    tblrd_req.valid <= 1'b0;
    @(posedge core_clk);
    chk({30'h0000_0000, tblrd_resp}, {30'h0000_0000, !dn, dn});
  endtask
  task automatic ext(input nvp_pkg::nvp_space_t sp, input logic dn);
    @(posedge core_clk);
    ext_req <= '{1'b1, sp};
    @(posedge core_clk);
    ext_req.valid <= 1'b0;
    @(posedge core_clk);
    chk({30'h0000_0000, ext_resp}, {30'h0000_0000, !dn, dn});
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial
  begin
    #20000;
    errors++;
    test_done();
  end
  initial
  begin
    {rst, psel, penable, pwrite, paddr, pwdata, pstrb} = {3'h4, 1'b0, 64'h0, 4'hf};
    nvm_code_cfg = 2'h3;
    tblrd_req = '0;
    ext_req = '0;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    rdc(A_GUARD, 32'h0000_020f);
    for (int i = 0; i < 2; i++)
    begin
      rdc(A_PART, {16'h0000, PID});
      rdc(A_REV, {16'h0000, REV});
      apb(1'b1, A_PART, 32'hffff_ffff, 4'hf);
      apb(1'b1, A_REV, 32'h0000_0000, 4'hf);
      chk({31'h0000_0000, err}, 32'h0000_0000);
    end
    $display("identity test done");
    for (int c = 0; c < 4; c++)
    begin
      nvm_code_cfg <= 2'(c);
      apb(1'b1, A_PROT, 32'(~c), 4'hf);
      rdc(A_PROT, 32'(c));
      chk({30'h0000_0000, data_protect_on, prog_protect_on}, {30'h0000_0000, ~nvm_code_cfg});
      ext(nvp_pkg::NVP_SPACE_DATA, !nvm_code_cfg[1]);
      ext(nvp_pkg::NVP_SPACE_PROGRAM, !nvm_code_cfg[0]);
    end
    $display("code protect test done");
    apb(1'b1, A_GUARD, 32'h0000_0000, 4'hf);
    rdc(A_GUARD, 32'h0000_0000);
    for (int t = 0; t < 5; t++)
    begin
      tbl(nvp_pkg::NVP_REG_OTHER, nvp_pkg::nvp_region_t'(t), 1'b1);
      tbl(nvp_pkg::nvp_region_t'(t), nvp_pkg::nvp_region_t'(t), 1'b0);
    end
    apb(1'b1, A_GUARD, 32'hffff_ffff, 4'h1);
    rdc(A_GUARD, 32'h0000_000f);
    for (int t = 0; t < 6; t++)
      tbl(nvp_pkg::NVP_REG_BLK3, nvp_pkg::nvp_region_t'(t), t == 0);
    apb(1'b1, A_GUARD, 32'hffff_ffff, 4'h2);
    rdc(A_GUARD, 32'h0000_020f);
    tbl(nvp_pkg::NVP_REG_BLK1, nvp_pkg::NVP_REG_BOOT, 1'b0);
    $display("read guard test done");
    apb(1'b0, 32'h0000_0100, 32'h0000_0000, 4'hf);
    chk({31'h0000_0000, err}, 32'h0000_0001);
    apb(1'b1, 32'h0000_0100, 32'h0000_0000, 4'hf);
    chk({31'h0000_0000, err}, 32'h0000_0001);
    $display("unmapped test done");
    test_done();
  end
endmodule
bind nvp_protect_regs nvp_protect_monitor #(.PART_ID(PART_ID), .FAMILY(FAMILY), .MAJOR_REV(MAJOR_REV),
  .MINOR_REV(MINOR_REV)) nvp_protect_monitor_i (.core_clk(core_clk), .rst(rst), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .nvm_code_cfg(nvm_code_cfg), .tblrd_req(tblrd_req), .tblrd_resp(tblrd_resp), .ext_req(ext_req),
  .ext_resp(ext_resp), .data_protect_on(data_protect_on), .prog_protect_on(prog_protect_on),
  .boot_guard_on(boot_guard_on), .block_guard_on(block_guard_on));
`default_nettype wire
